/* File: shared/trip_pkg.sv */
// constants, types and address map of the phase-selective trip logic
// assumes a single 25 MHz clock and AHB-Lite register access
package trip_pkg;
  // ----------------------------------------
  // modes
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_OFF, MODE_THREE_ONLY, MODE_SINGLE_THREE} trip_mode_t;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MIN_PULSE_OFS = 8'h04;
  localparam logic [7:0] EVOLVE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] EVENT_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int EVT_GENERAL_BIT = 3;
  localparam int STAT_ANY_BIT = 3;
  localparam int STAT_ALL_BIT = 4;
  localparam int STAT_MODE_LSB = 5;
  localparam logic [15:0] MIN_PULSE_RST = 16'h0096;
  localparam logic [15:0] EVOLVE_RST = 16'h03e8;
  localparam logic [15:0] MS_SETTING_MIN = 16'h0032;
  localparam logic [15:0] MS_SETTING_MAX = 16'hea60;
  localparam logic [3:0] MASK_RST = 4'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage

/* File: shared/ms_timer_if.sv */
// load and busy handshake between the trip core and one millisecond timer
// assumes tick is a one-cycle enable on the same clock
`timescale 1ns/1ps
interface ms_timer_if;
  logic tick;
  logic load;
  logic [15:0] load_ms;
  logic busy;
  modport timer (input tick, input load, input load_ms, output busy);
  modport ctrl (output tick, output load, output load_ms, input busy);
endinterface

/* File: rtl/ms_tick_gen.sv */
// divider producing a one-cycle pulse every millisecond
// assumes ref_clk at the package rate; TICK is shortened in simulation
`timescale 1ns/1ps
module ms_tick_gen import trip_pkg::*; #(
  parameter int TICK = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  output logic tick
);
  logic [31:0] cnt_q;
  logic wrap;

  assign wrap = cnt_q == 32'(TICK - 1);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
      tick <= wrap;
    end
  end

  a_tick_single_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && TICK > 1 |=> !tick)
    else $error("tick lasted longer than one cycle");
endmodule

/* File: rtl/ms_timer.sv */
// countdown in milliseconds, busy while running
// one extra count on load so a partial first tick never shortens the time
`timescale 1ns/1ps
module ms_timer (
  input wire logic ref_clk,
  input wire logic nrst,
  ms_timer_if.timer tmr
);
  logic [16:0] cnt_q;
  logic [16:0] cnt_d;

  assign cnt_d = tmr.load ? 17'(tmr.load_ms) + 17'h1 :
                 (tmr.tick && cnt_q != 17'h0) ? cnt_q - 17'h1 : cnt_q;
  assign tmr.busy = cnt_q != 17'h0;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_q <= 17'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  a_timer_starts: assert property (@(posedge ref_clk) disable iff (!nrst)
    tmr.load |=> tmr.busy && cnt_q == 17'($past(tmr.load_ms)) + 17'h1)
    else $error("timer did not start on load");
  a_timer_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    !tmr.load && !tmr.tick |=> $stable(cnt_q))
    else $error("timer moved without a tick");
endmodule

/* File: rtl/trip_logic.sv */
// phase-selective trip decision with AHB-Lite registers and event interrupt
// assumes request inputs come from logic on ref_clk; one slave on the bus
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module trip_logic import trip_pkg::*; #(
  parameter int TICK = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic output_block_in,
  input wire logic single_phase_request_in,
  input wire logic three_phase_request_in,
  input wire logic phase_a_request_in,
  input wire logic phase_b_request_in,
  input wire logic phase_c_request_in,
  input wire logic force_all_phases_in,
  output logic phase_a_trip_out,
  output logic phase_b_trip_out,
  output logic phase_c_trip_out,
  output logic any_trip_out,
  output logic all_phase_trip_out,
  output logic irq
);
  // ----------------------------------------
  // timers
  // ----------------------------------------
  logic tick;
  ms_timer_if pulse_if ();
  ms_timer_if evolve_if ();

  ms_tick_gen #(.TICK(TICK)) u_tick (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick)
  );
  ms_timer u_pulse (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tmr(pulse_if.timer)
  );
  ms_timer u_evolve (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tmr(evolve_if.timer)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  trip_mode_t mode_q;
  logic [15:0] min_pulse_q;
  logic [15:0] evolve_q;
  logic [3:0] evt_q;
  logic [3:0] evt_d;
  logic [3:0] mask_q;
  logic [2:0] trip_q;
  logic [2:0] trip_d;
  logic [2:0] ph_prev_q;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic accept;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic wr_ctrl, wr_pulse, wr_evolve, wr_event, wr_mask;
  logic [31:0] rd_mux;
  logic [15:0] ms_wdata;
  logic [3:0] evt_clr;

  assign accept = hsel && hready && htrans[1];
  assign wr_ctrl = wr_pend_q && wr_addr_q == CTRL_OFS;
  assign wr_pulse = wr_pend_q && wr_addr_q == MIN_PULSE_OFS;
  assign wr_evolve = wr_pend_q && wr_addr_q == EVOLVE_OFS;
  assign wr_event = wr_pend_q && wr_addr_q == EVENT_OFS;
  assign wr_mask = wr_pend_q && wr_addr_q == MASK_OFS;
  // out-of-range settings are pulled to the nearest legal value
  assign ms_wdata = hwdata[15:0] < MS_SETTING_MIN ? MS_SETTING_MIN :
                    hwdata[15:0] > MS_SETTING_MAX ? MS_SETTING_MAX : hwdata[15:0];
  assign evt_clr = wr_event ? hwdata[3:0] : 4'h0;

  assign rd_mux = haddr[7:0] == CTRL_OFS ? {30'h0, mode_q} :
                  haddr[7:0] == MIN_PULSE_OFS ? {16'h0, min_pulse_q} :
                  haddr[7:0] == EVOLVE_OFS ? {16'h0, evolve_q} :
                  haddr[7:0] == STATUS_OFS ? {25'h0, mode_q, all_phase_trip_out, any_trip_out, trip_q} :
                  haddr[7:0] == EVENT_OFS ? {28'h0, evt_q} :
                  haddr[7:0] == MASK_OFS ? {28'h0, mask_q} : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= accept && hwrite && haddr[31:8] == 24'h0;
      wr_addr_q <= haddr[7:0];
      hrdata <= (accept && !hwrite && haddr[31:8] == 24'h0) ? rd_mux : 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_q <= MODE_OFF;
      min_pulse_q <= MIN_PULSE_RST;
      evolve_q <= EVOLVE_RST;
      mask_q <= MASK_RST;
    end else begin
      if (wr_ctrl) begin
        mode_q <= hwdata[1:0] == 2'h3 ? MODE_OFF : trip_mode_t'(hwdata[1:0]);
      end
      if (wr_pulse) begin
        min_pulse_q <= ms_wdata;
      end
      if (wr_evolve) begin
        evolve_q <= ms_wdata;
      end
      if (wr_mask) begin
        mask_q <= hwdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // trip decision
  // ----------------------------------------
  logic active, pair, req_any, new_fault, widen, onset, any_d, all_d;
  logic [2:0] ph_req, req_set;

  assign ph_req = {phase_c_request_in, phase_b_request_in, phase_a_request_in};
  assign active = mode_q != MODE_OFF && !output_block_in;
  assign pair = (ph_req[0] && ph_req[1]) || (ph_req[1] && ph_req[2]) || (ph_req[0] && ph_req[2]);
  assign req_any = |ph_req || three_phase_request_in || single_phase_request_in;
  assign new_fault = |(ph_req & ~ph_prev_q);
  assign widen = three_phase_request_in || force_all_phases_in || mode_q == MODE_THREE_ONLY || pair ||
                 (evolve_if.busy && new_fault);
  // a request with no phase named cannot be confined, so it trips all phases
  assign req_set = (widen || ph_req == 3'h0) ? 3'h7 : ph_req;
  assign trip_d = !active ? 3'h0 :
                  req_any ? (trip_q | req_set) :
                  pulse_if.busy ? trip_q : 3'h0;
  assign any_d = |trip_d;
  assign all_d = &trip_d;
  assign onset = any_d && trip_q == 3'h0;

  assign pulse_if.tick = tick;
  assign pulse_if.load = onset;
  assign pulse_if.load_ms = min_pulse_q;
  assign evolve_if.tick = tick;
  assign evolve_if.load = onset;
  assign evolve_if.load_ms = evolve_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trip_q <= 3'h0;
      ph_prev_q <= 3'h0;
      any_trip_out <= 1'b0;
      all_phase_trip_out <= 1'b0;
    end else begin
      trip_q <= trip_d;
      ph_prev_q <= ph_req;
      any_trip_out <= any_d;
      all_phase_trip_out <= all_d;
    end
  end

  assign phase_a_trip_out = trip_q[0];
  assign phase_b_trip_out = trip_q[1];
  assign phase_c_trip_out = trip_q[2];

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  logic [3:0] chg;

  assign chg = {any_d ^ any_trip_out, trip_d ^ trip_q};
  // a change in the same cycle as a clear keeps its bit set
  assign evt_d = (evt_q & ~evt_clr) | chg;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      evt_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      evt_q <= evt_d;
      irq <= |(evt_d & mask_q);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [16:0] held_ticks_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      held_ticks_q <= 17'h0;
    end else begin
      held_ticks_q <= !any_trip_out ? 17'h0 : held_ticks_q + {16'h0, tick};
    end
  end

  sequence s_trip_starts;
    !any_trip_out ##1 any_trip_out;
  endsequence
  sequence s_trip_ends_free;
    any_trip_out && mode_q != MODE_OFF && !output_block_in && !req_any ##1 !any_trip_out;
  endsequence
  sequence s_phase_moves;
    trip_q != $past(trip_q);
  endsequence

  a_mode_after_reset: assert property (@(posedge ref_clk)
    !nrst |=> mode_q == MODE_OFF)
    else $error("mode not off after reset");
  a_min_pulse_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_trip_ends_free |-> $past(held_ticks_q) >= {1'b0, $past(min_pulse_q, 2)})
    else $error("trip released before minimum pulse time");
  a_evolve_widens: assert property (@(posedge ref_clk) disable iff (!nrst)
    active && evolve_if.busy && new_fault |=> trip_q == 3'h7)
    else $error("evolving fault did not trip all phases");
  a_pair_widens: assert property (@(posedge ref_clk) disable iff (!nrst)
    active && pair |=> trip_q == 3'h7 && all_phase_trip_out)
    else $error("two-phase fault did not include third phase");
  a_block_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    output_block_in |=> !any_trip_out && trip_q == 3'h0)
    else $error("trip output while blocked");
  a_force_all: assert property (@(posedge ref_clk) disable iff (!nrst)
    active && force_all_phases_in && req_any |=> all_phase_trip_out)
    else $error("forced trip not three-phase");
  a_single_confined: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_q == MODE_SINGLE_THREE && !output_block_in && trip_q == 3'h0 && ph_req == 3'h1 &&
    // inside the evolving time a fresh fault widens instead
    !three_phase_request_in && !force_all_phases_in &&
    !evolve_if.busy |=> trip_q == 3'h1 && !all_phase_trip_out)
    else $error("single-phase trip not confined to its phase");
  a_general_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
    any_trip_out == (trip_q != 3'h0))
    else $error("general trip disagrees with phase trips");
  a_three_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
    all_phase_trip_out == (trip_q == 3'h7))
    else $error("three-phase trip disagrees with phase trips");
  a_event_raised: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_phase_moves |-> (evt_q[2:0] & (trip_q ^ $past(trip_q))) == (trip_q ^ $past(trip_q)))
    else $error("phase change raised no event");
  a_general_event: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_trip_starts |-> evt_q[EVT_GENERAL_BIT])
    else $error("general trip change raised no event");
  a_off_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_q == MODE_OFF |=> trip_q == 3'h0)
    else $error("trip output while mode off");
  a_three_only_all: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_q == MODE_THREE_ONLY && !output_block_in && req_any |=> trip_q == 3'h7)
    else $error("three-phase-only mode tripped fewer phases");

  sequence s_trip_ends;
    any_trip_out ##1 !any_trip_out;
  endsequence

  a_request_trips: assert property (@(posedge ref_clk) disable iff (!nrst)
    active && req_any |=> any_trip_out)
    else $error("request did not raise the general trip");
  a_phase_requested: assert property (@(posedge ref_clk) disable iff (!nrst)
    active && req_any |=> (trip_q & $past(ph_req)) == $past(ph_req))
    else $error("requested phase not tripped");
  a_pulse_starts: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_trip_starts |-> pulse_if.busy)
    else $error("minimum pulse timer not started at trip onset");
  a_pulse_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    active && any_trip_out && pulse_if.busy |=> any_trip_out)
    else $error("trip dropped while minimum pulse timer ran");
  a_evolve_starts: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_trip_starts |-> evolve_if.busy)
    else $error("evolving-fault timer not started at trip onset");

  // ----------------------------------------
  // register and interrupt checks
  // ----------------------------------------
  a_mode_code_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_ctrl && hwdata[1:0] == 2'h3 |=> mode_q == MODE_OFF)
    else $error("reserved mode code did not select off");
  a_pulse_in_range: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_pulse |=> min_pulse_q >= MS_SETTING_MIN && min_pulse_q <= MS_SETTING_MAX)
    else $error("minimum pulse setting outside its range");
  a_evolve_in_range: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_evolve |=> evolve_q >= MS_SETTING_MIN && evolve_q <= MS_SETTING_MAX)
    else $error("evolving time setting outside its range");
  // irq is registered from evt_d, so it sees the mask of the cycle before
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    irq == |(evt_q & $past(mask_q)))
    else $error("interrupt disagrees with masked events");
  a_event_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_event && chg == 4'h0 |=> (evt_q & $past(hwdata[3:0])) == 4'h0)
    else $error("written event bits not cleared");
  a_general_event_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_trip_ends |-> evt_q[EVT_GENERAL_BIT])
    else $error("general trip release raised no event");
endmodule

/* File: bench/req_source.sv */
// request source standing in for the protection functions
// assumes the bench calls drive() from its main process only
`timescale 1ns/1ps
module req_source (
  input wire logic ref_clk,
  output logic [6:0] req
);
  // bits: 0..2 phase a..c, 3 single, 4 three, 5 force, 6 block
  initial req = 7'h00;

  // hold n edges; long holds model a slow protection function
  task automatic drive(input logic [6:0] c, input int n);
    @(posedge ref_clk);
    req <= c;
    repeat (n) @(posedge ref_clk);
    req <= 7'h00;
  endtask
endmodule

/* File: bench/trip_logic_tb.sv */
// self-checking bench for the phase-selective trip logic
// assumes TICK shortened to 10 cycles per ms and one bus slave
`timescale 1ns/1ps
module trip_logic_tb;
  import trip_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int TK = 10;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic any_t;
  logic all_t;
  logic [2:0] trip;
  logic [2:0] p;
  logic [6:0] req;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'h5407;
  int min_ms = 150;
  int mode = 0;

  always #20 ref_clk = ~ref_clk;

  trip_logic #(.TICK(TK)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .output_block_in(req[6]), .single_phase_request_in(req[3]),
    .three_phase_request_in(req[4]), .phase_a_request_in(req[0]),
    .phase_b_request_in(req[1]), .phase_c_request_in(req[2]),
    .force_all_phases_in(req[5]), .phase_a_trip_out(trip[0]),
    .phase_b_trip_out(trip[1]), .phase_c_trip_out(trip[2]),
    .any_trip_out(any_t), .all_phase_trip_out(all_t), .irq(irq));

  req_source u_req (.ref_clk(ref_clk), .req(req));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // entered just after a rising edge; no fixed wait assumed
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(a, 1'h0, 32'h0);
    check("rdata", rd, e);
    check("hresp", hresp, 32'h0);
  endtask

  // reference model; evo marks a new fault inside the waiting time
  function automatic logic [2:0] model(input logic [6:0] r, input bit evo);
    int n;
    n = r[0] + r[1] + r[2];
    if (mode == 0 || r[6]) return 3'h0;
    if (mode == 1 || r[5] || r[4] || n != 1 || evo) return 3'h7;
    return r[2:0];
  endfunction

  task automatic trip_case(input logic [6:0] r, input bit evo, input int gap);
    logic [2:0] e;
    logic [31:0] st;
    int w;
    e = model(r, evo);
    u_req.drive(r, 1);
    w = 0;
    while (any_t !== 1'h1 && w < 20) begin
      @(posedge ref_clk);
      w++;
    end
    check("phases", trip, e);
    check("any", any_t, e != 0);
    check("all", all_t, e == 3'h7);
    st = 32'(e) | (32'(e != 3'h0) << STAT_ANY_BIT) | (32'(e == 3'h7) << STAT_ALL_BIT);
    rchk(STATUS_OFS, st | (32'(mode) << STAT_MODE_LSB));
    if (e != 0) begin
      w = 0;
      while (any_t === 1'h1 && w < 2000) begin
        @(posedge ref_clk);
        w++;
      end
      check("pulse", w >= min_ms * TK - 3 && w <= (min_ms + 1) * TK + 3, 1);
    end
    repeat (gap) @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'h1;
    @(posedge ref_clk);
    rchk(CTRL_OFS, 32'h0);
    rchk(MIN_PULSE_OFS, 32'h96);
    rchk(EVOLVE_OFS, 32'h3e8);
    rchk(MASK_OFS, 32'h0);
    rchk(8'h18, 32'h0);
    trip_case(7'h01, 0, 0);
    for (int m = 0; m < 4; m++) begin
      ahb(CTRL_OFS, 1'h1, m);
      rchk(CTRL_OFS, (m == 3) ? 0 : m);
    end
    ahb(MIN_PULSE_OFS, 1'h1, 32'h5);
    rchk(MIN_PULSE_OFS, 32'h32);
    ahb(MIN_PULSE_OFS, 1'h1, 32'hffff);
    rchk(MIN_PULSE_OFS, 32'hea60);
    ahb(MIN_PULSE_OFS, 1'h1, 32'h32);
    min_ms = 50;
    ahb(EVOLVE_OFS, 1'h1, 32'h64);
    rchk(EVOLVE_OFS, 32'h64);
    mode = 2;
    ahb(CTRL_OFS, 1'h1, 32'h2);
    ahb(MASK_OFS, 1'h1, 32'h8);
    ahb(EVENT_OFS, 1'h1, 32'hf);
    trip_case(7'h09, 0, 0);
    rchk(EVENT_OFS, 32'h9);
    check("irq", irq, 32'h1);
    ahb(EVENT_OFS, 1'h1, 32'hf);
    rchk(EVENT_OFS, 32'h0);
    check("irq", irq, 32'h0);
    // second fault well inside the 100 ms waiting time
    trip_case(7'h0a, 1, 700);
    repeat (3) begin
      p = 3'h1 << ($unsigned($random(seed)) % 3);
      trip_case({3'h0, 1'h1, p}, 0, 700);
    end
    trip_case(7'h03, 0, 700);
    trip_case(7'h21, 0, 700);
    trip_case(7'h10, 0, 700);
    trip_case(7'h41, 0, 700);
    u_req.drive(7'h01, 1);
    repeat (3) @(posedge ref_clk);
    u_req.drive(7'h40, 3);
    check("blocked", {any_t, trip}, 32'h0);
    repeat (700) @(posedge ref_clk);
    mode = 1;
    ahb(CTRL_OFS, 1'h1, 32'h1);
    trip_case(7'h0c, 0, 20);
    ahb(MASK_OFS, 1'h1, 32'h0);
    rchk(EVENT_OFS, 32'hf);
    check("irq", irq, 32'h0);
    report_and_stop();
  end

  // hang guard, well beyond the roughly 11k cycles the sequence takes
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    report_and_stop();
  end
endmodule
